// ### design/cgc_group_config.sv
// Purpose: group configuration word, its effects on sync, polling, write-back and violations
// Assumes: one clock, synchronous active-low reset, ahb-lite slave with zero wait states
// Notes: the word is staged by software and made live by a service request
`timescale 1ns/100ps
`include "cgc_map.svh"

module cgc_group_config #(
    parameter int NUM_CH = 32,
    parameter int SLOT_W = 5
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // ahb-lite slave
    input wire logic hsel_in,
    input wire logic [11:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // serial interface timing
    input wire logic [SLOT_W-1:0] time_slot_in,
    input wire logic tx_frame_sync_in,
    input wire logic rx_frame_sync_in,
    // channel events
    input wire logic su_error_in,
    input wire logic channel_activate_in,
    input wire logic [4:0] activate_channel_in,
    input wire logic tx_buffer_end_in,
    input wire logic rx_buffer_end_in,
    input wire logic mem_violation_in,
    input wire logic [4:0] serviced_channel_in,
    // outputs toward the dma and channel machinery
    output logic frame_sync_out,
    output logic poll_strobe_out,
    output logic [NUM_CH-1:0] channel_running_out,
    output logic tx_status_wb_out,
    output logic rx_status_wb_out,
    output cgc_pkg::cgc_deact_t deact_out,
    output logic su_error_interrupt_out,
    output logic irq_out
);

    // refused at elaboration: channel numbers are fixed five-bit fields
    if (NUM_CH != 32) begin : g_bad_num_ch
        $error("channel group must hold 32 channels");
    end
    // a zero-width slot counter could never roll over
    if (SLOT_W < 1) begin : g_bad_slot_w
        $error("time slot counter needs at least one bit");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bus decode

    // bus-side and configuration state
    logic [11:0] addr_q;
    logic wr_q;
    logic rd_q;
    logic [31:0] staged;
    logic [31:0] active;
    logic [4:0] service_code;
    logic [`CGC_IRQ_BITS-1:0] irq_stat;
    logic [`CGC_IRQ_BITS-1:0] irq_en;
    logic [7:0] su_count;
    cgc_pkg::cgc_state_t state;
    cgc_pkg::cgc_cfg_t cfg;
    logic access;
    logic svc_write;
    logic clr_write;

    // only a qualified nonseq or seq address phase is taken
    assign access = hsel_in && hready_in && htrans_in[1];
    assign hreadyout_out = 1'b1; // zero wait states keep the master simple
    assign hresp_out = 1'b0;

    // address phase capture
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            addr_q <= 12'h000;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
        end else begin
            addr_q <= haddr_in;
            wr_q <= access && hwrite_in;
            rd_q <= access && !hwrite_in;
        end
    end

    // data-phase strobes; hwdata_in stands in the same cycle
    assign svc_write = wr_q && (addr_q == `CGC_OFF_SERVICE);
    assign clr_write = wr_q && (addr_q == `CGC_OFF_IRQ_CLR);

    // staged word and interrupt enables; reserved bits are dropped
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            staged <= `CGC_CFG_RESET;
            irq_en <= '0;
        end else if (wr_q) begin
            if (addr_q == `CGC_OFF_STAGED)
                staged <= hwdata_in & `CGC_WRITABLE_MASK;
            if (addr_q == `CGC_OFF_IRQ_EN)
                irq_en <= hwdata_in[`CGC_IRQ_BITS-1:0];
        end
    end

    // read data mux
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            hrdata_out <= 32'h00000000;
        end else if (access && !hwrite_in) begin
            case (haddr_in)
                `CGC_OFF_STAGED: hrdata_out <= staged;
                `CGC_OFF_ACTIVE: hrdata_out <= active;
                `CGC_OFF_SERVICE: hrdata_out <= {27'h0000000, service_code};
                `CGC_OFF_STATUS: hrdata_out <= {29'h00000000, state};
                `CGC_OFF_IRQ_STAT: hrdata_out <= {26'h0000000, irq_stat};
                `CGC_OFF_IRQ_EN: hrdata_out <= {26'h0000000, irq_en};
                `CGC_OFF_SU_ERROR_INTERRUPT_CNT: hrdata_out <= {24'h000000, su_count};
                default: hrdata_out <= 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // service request and load sequence

    // the live word changes only via the service code, at any point of a frame; a staged-word write alone never changes it
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            state <= cgc_pkg::CGC_IDLE;
            service_code <= 5'h00;
            active <= `CGC_CFG_RESET;
        end else begin
            case (state)
                cgc_pkg::CGC_IDLE: begin
                    if (svc_write) begin
                        service_code <= hwdata_in[4:0];
                        if (hwdata_in[4:0] == `CGC_SVC_LOAD_CFG)
                            state <= cgc_pkg::CGC_LOAD;
                    end
                end
                cgc_pkg::CGC_LOAD: begin
                    active <= staged;
                    state <= cgc_pkg::CGC_DONE;
                end
                cgc_pkg::CGC_DONE: state <= cgc_pkg::CGC_IDLE;
                default: state <= cgc_pkg::CGC_IDLE;
            endcase
        end
    end

    // one decoded word serves every channel of the group
    assign cfg.su_threshold = active[`CGC_SIGNAL_UNIT_ERROR_THRESHOLD_MSB:`CGC_SIGNAL_UNIT_ERROR_THRESHOLD_LSB];
    assign cfg.sf_align = active[`CGC_SUPERFRAME_ALIGN_SELECT_BIT];
    assign cfg.poll_throttle = active[`CGC_POLL_THROTTLE_MSB:`CGC_POLL_THROTTLE_LSB];
    assign cfg.inh_tx = active[`CGC_INHTX_BIT];
    assign cfg.inh_rx = active[`CGC_INHRX_BIT];
    assign cfg.mem_action = active[`CGC_MEM_VIOLATION_ACTION_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // frame synchronisation event

    logic [SLOT_W-1:0] slot_q;
    logic ext_sync_q;
    logic rollover;
    logic ext_rise;
    logic next_sync;

    // previous slot and sync level for edge detection
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            slot_q <= '0;
            ext_sync_q <= 1'b0;
        end else begin
            slot_q <= time_slot_in;
            ext_sync_q <= tx_frame_sync_in || rx_frame_sync_in;
        end
    end

    // slot_q resets to zero, so a slot held at zero after reset is no false roll-over
    assign rollover = (time_slot_in == '0) && (slot_q != '0);
    assign ext_rise = (tx_frame_sync_in || rx_frame_sync_in) && !ext_sync_q;
    assign next_sync = cfg.sf_align ? ext_rise : rollover;

    // registered event pulse
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in)
            frame_sync_out <= 1'b0;
        else
            frame_sync_out <= next_sync;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // channel start gating

    // waiting for the first sync after activation, one bit per channel
    logic [NUM_CH-1:0] pending;

    // an activated transparent channel waits for the next sync event
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            pending <= '0;
            channel_running_out <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (deact_out.valid && (deact_out.all || deact_out.channel == 5'(i))) begin
                    pending[i] <= 1'b0;
                    channel_running_out[i] <= 1'b0;
                end else if (channel_activate_in && activate_channel_in == 5'(i)) begin
                    pending[i] <= 1'b1;
                    channel_running_out[i] <= 1'b0;
                end else if (pending[i] && next_sync) begin
                    pending[i] <= 1'b0;
                    channel_running_out[i] <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // descriptor polling

    // seven bits reach the longest spacing of 64 events
    logic [6:0] poll_cnt;
    logic [6:0] poll_div;
    logic poll_hit;

    // encoding 0 is unsupported; it is treated as every 16th to stay bounded
    always_comb begin
        case (cfg.poll_throttle)
            2'h2: poll_div = `CGC_POLL_DIV_2;
            2'h3: poll_div = `CGC_POLL_DIV_3;
            default: poll_div = `CGC_POLL_DIV_1;
        endcase
    end

    // the event that completes the count fires the poll and restarts it
    assign poll_hit = next_sync && (poll_cnt >= poll_div - 7'h01);

    // count sync events between polls
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            poll_cnt <= 7'h00;
            poll_strobe_out <= 1'b0;
        end else begin
            poll_strobe_out <= poll_hit;
            if (poll_hit)
                poll_cnt <= 7'h00;
            else if (next_sync)
                poll_cnt <= poll_cnt + 7'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // buffer status write-back

    // a write-back request per buffer end unless inhibited
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            tx_status_wb_out <= 1'b0;
            rx_status_wb_out <= 1'b0;
        end else begin
            tx_status_wb_out <= tx_buffer_end_in && !cfg.inh_tx;
            rx_status_wb_out <= rx_buffer_end_in && !cfg.inh_rx;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // memory protection violation

    // whole group or serviced channel only
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            deact_out <= '0;
        end else begin
            deact_out.valid <= mem_violation_in;
            deact_out.all <= mem_violation_in && !cfg.mem_action;
            deact_out.channel <= serviced_channel_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // signal unit error monitor

    logic su_over;

    // saturating count, cleared by a config load
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in)
            su_count <= 8'h00;
        else if (state == cgc_pkg::CGC_DONE)
            su_count <= 8'h00;
        else if (su_error_in && su_count != 8'hff)
            su_count <= su_count + 8'h01;
    end

    // zero-extended so the compare is done at the counter's width
    assign su_over = su_count > {2'b00, cfg.su_threshold};

    // level interrupt while the count exceeds the threshold
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in)
            su_error_interrupt_out <= 1'b0;
        else
            su_error_interrupt_out <= su_over;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt status

    logic [`CGC_IRQ_BITS-1:0] irq_set;
    logic [`CGC_IRQ_BITS-1:0] irq_clr;

    // one set pulse per event
    always_comb begin
        irq_set = '0;
        irq_set[`CGC_IRQ_SU_ERROR_INTERRUPT] = su_over && !su_error_interrupt_out;
        irq_set[`CGC_IRQ_POLL] = poll_hit;
        irq_set[`CGC_IRQ_GRP_RST] = mem_violation_in && !cfg.mem_action;
        irq_set[`CGC_IRQ_CH_DEACT] = mem_violation_in && cfg.mem_action;
        irq_set[`CGC_IRQ_CFG_LOAD] = state == cgc_pkg::CGC_DONE;
        irq_set[`CGC_IRQ_BAD_THR] = state == cgc_pkg::CGC_DONE && cfg.poll_throttle == 2'h0;
    end

    // clear mask only during the data phase of a clear write
    assign irq_clr = clr_write ? hwdata_in[`CGC_IRQ_BITS-1:0] : '0;

    // sticky bits; a new event beats a simultaneous clear
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in)
            irq_stat <= '0;
        else
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
    end

    // unregistered level, so a mask change takes effect at once
    assign irq_out = |(irq_stat & irq_en);

endmodule

// ### design/cgc_map.svh
// Purpose: offsets, field positions, reset values and timing counts for the group config block
// Assumes: 32-bit ahb-lite register bus, word aligned
// Notes: included by the design module; the package holds only types
// Function
// - an su error interrupt is raised while the error count exceeds the threshold in 21:16.
// - superframe_align_select 0: the slot counter roll-over to zero is the sync event.
// - superframe_align_select 0: a new transparent channel waits for the next roll-over.
// - superframe_align_select 1: sync event is tx_frame_sync or rx_frame_sync asserting.
// - superframe_align_select 1: a new transparent channel waits for the external sync.
// - descriptor polling is timed from the selected sync event, scaled by poll_throttle.
// - poll_throttle (11:10) 1, 2, 3 polls each 16th, 32nd, 64th event; 0 is unsupported.
// - inhibit_tx_status_writeback (bit 9) at 0: tx status is written back per tx buffer.
// - inhibit_tx_status_writeback at 1: no tx write-back, the host relies on interrupts.
// - inhibit_rx_status_writeback (bit 8) at 0: rx status is written back per rx buffer.
// - inhibit_rx_status_writeback at 1: no rx write-back, the host relies on interrupts.
// - mem_violation_action (bit 7) at 0: a violation resets all 32 channels both ways.
// - mem_violation_action at 1: a violation stops only the serviced channel, both ways.
// - the configuration word applies uniformly to all 32 channels of the group.
// - service code 18 makes the device load a fresh copy of the configuration word.
`ifndef CGC_MAP_SVH
`define CGC_MAP_SVH

`define CGC_OFF_STAGED 12'h000
`define CGC_OFF_ACTIVE 12'h004
`define CGC_OFF_SERVICE 12'h008
`define CGC_OFF_STATUS 12'h00c
`define CGC_OFF_IRQ_STAT 12'h010
`define CGC_OFF_IRQ_CLR 12'h014
`define CGC_OFF_IRQ_EN 12'h018
`define CGC_OFF_SU_ERROR_INTERRUPT_CNT 12'h01c

`define CGC_SIGNAL_UNIT_ERROR_THRESHOLD_LSB 16
`define CGC_SIGNAL_UNIT_ERROR_THRESHOLD_MSB 21
`define CGC_SUPERFRAME_ALIGN_SELECT_BIT 15
`define CGC_POLL_THROTTLE_LSB 10
`define CGC_POLL_THROTTLE_MSB 11
`define CGC_INHTX_BIT 9
`define CGC_INHRX_BIT 8
`define CGC_MEM_VIOLATION_ACTION_BIT 7
`define CGC_WRITABLE_MASK 32'h003f8f80

`define CGC_CFG_RESET 32'h00000400
`define CGC_SVC_LOAD_CFG 5'h12

`define CGC_POLL_DIV_1 7'h10
`define CGC_POLL_DIV_2 7'h20
`define CGC_POLL_DIV_3 7'h40

`define CGC_IRQ_SU_ERROR_INTERRUPT 0
`define CGC_IRQ_POLL 1
`define CGC_IRQ_GRP_RST 2
`define CGC_IRQ_CH_DEACT 3
`define CGC_IRQ_CFG_LOAD 4
`define CGC_IRQ_BAD_THR 5
`define CGC_IRQ_BITS 6

`endif

// ### design/cgc_pkg.sv
// Purpose: types for the group config block
// Assumes: cgc_map.svh holds the numbers
// Notes: no imports, users write cgc_pkg::name
package cgc_pkg;

    // decoded configuration word
    typedef struct packed {
        logic [5:0] su_threshold;
        logic sf_align;
        logic [1:0] poll_throttle;
        logic inh_tx;
        logic inh_rx;
        logic mem_action;
    } cgc_cfg_t;

    // channel deactivation command
    typedef struct packed {
        logic valid;
        logic all;
        logic [4:0] channel;
    } cgc_deact_t;

    // load sequencer states
    typedef enum logic [2:0] {
        CGC_IDLE = 3'b001,
        CGC_LOAD = 3'b010,
        CGC_DONE = 3'b100
    } cgc_state_t;

endpackage

// ### dv/cgc_group_config_assertions.sv
// Purpose: port-level checks of the group config block
// Assumes: one clock, synchronous active-low reset
// Notes: bound into every cgc_group_config instance
`timescale 1ns/100ps
module cgc_chk #(
    parameter int NUM_CH = 32,
    parameter int SLOT_W = 5
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    input wire logic [SLOT_W-1:0] time_slot_in,
    input wire logic tx_frame_sync_in,
    input wire logic rx_frame_sync_in,
    input wire logic tx_buffer_end_in,
    input wire logic rx_buffer_end_in,
    input wire logic mem_violation_in,
    input wire logic [4:0] serviced_channel_in,
    input wire logic frame_sync_out,
    input wire logic poll_strobe_out,
    input wire logic [NUM_CH-1:0] channel_running_out,
    input wire logic tx_status_wb_out,
    input wire logic rx_status_wb_out,
    input wire cgc_pkg::cgc_deact_t deact_out
);
    logic sync_or;
    logic [6:0] fs_cnt;
    logic [6:0] fs_now;
    ////////////////////////////////////////////////////////////////
    // sync events since the last poll; a reload mid-run would skew it
    assign sync_or = tx_frame_sync_in | rx_frame_sync_in;
    assign fs_now = fs_cnt + {6'h00, frame_sync_out};
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in || poll_strobe_out) fs_cnt <= 7'h00;
        else fs_cnt <= fs_now;
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    ////////////////////////////////////////////////////////////////
    property p_fs;
        frame_sync_out |-> ($past(time_slot_in) == '0 && $past(time_slot_in, 2) != '0)
            || ($past(sync_or) && !$past(sync_or, 2));
    endproperty
    a_fs: assert property (p_fs) else $error("sync pulse without cause");
    property p_poll_cnt;
        poll_strobe_out |-> fs_now inside {7'h10, 7'h20, 7'h40};
    endproperty
    a_poll_cnt: assert property (p_poll_cnt) else $error("poll spacing off");
    property p_poll_sync;
        poll_strobe_out |-> frame_sync_out || $past(frame_sync_out);
    endproperty
    a_poll_sync: assert property (p_poll_sync) else $error("poll off sync");
    property p_start;
        |(channel_running_out & ~$past(channel_running_out))
            |-> frame_sync_out || $past(frame_sync_out);
    endproperty
    a_start: assert property (p_start) else $error("channel start off sync");
    property p_txwb;
        tx_status_wb_out |-> $past(tx_buffer_end_in);
    endproperty
    a_txwb: assert property (p_txwb) else $error("stray tx write-back");
    property p_rxwb;
        rx_status_wb_out |-> $past(rx_buffer_end_in);
    endproperty
    a_rxwb: assert property (p_rxwb) else $error("stray rx write-back");
    property p_deact;
        deact_out.valid |-> $past(mem_violation_in);
    endproperty
    a_deact: assert property (p_deact) else $error("stray deactivation");
    property p_deact_ch;
        deact_out.valid && !deact_out.all |-> deact_out.channel == $past(serviced_channel_in);
    endproperty
    a_deact_ch: assert property (p_deact_ch) else $error("wrong channel");
    property p_grp_clr;
        deact_out.valid && deact_out.all |-> ##[0:2] channel_running_out == '0;
    endproperty
    a_grp_clr: assert property (p_grp_clr) else $error("group not cleared");
    property p_bus;
        hreadyout_out && !hresp_out;
    endproperty
    a_bus: assert property (p_bus) else $error("bus not ready or error");
    c_poll: cover property (poll_strobe_out);
    c_grp: cover property (deact_out.valid && deact_out.all);
    c_one: cover property (deact_out.valid && !deact_out.all);
endmodule
bind cgc_group_config cgc_chk #(.NUM_CH(NUM_CH), .SLOT_W(SLOT_W)) cgc_chk_inst (
    .sys_clk_in, .rst_n_in, .hreadyout_out, .hresp_out, .time_slot_in,
    .tx_frame_sync_in, .rx_frame_sync_in, .tx_buffer_end_in, .rx_buffer_end_in,
    .mem_violation_in, .serviced_channel_in, .frame_sync_out, .poll_strobe_out,
    .channel_running_out, .tx_status_wb_out, .rx_status_wb_out, .deact_out);

// ### dv/cgc_serial_model.sv
// Purpose: serial interface timing seen by the block
// Assumes: slot counter and sync only move while run_in is high
// Notes: external sync every other frame, apart from the roll-over
`timescale 1ns/100ps
module cgc_serial_model #(
    parameter int SLOT_W = 3
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic run_in,
    output logic [SLOT_W-1:0] slot_out,
    output logic tx_sync_out,
    output logic rx_sync_out
);
    logic frame_odd;
    // counter stands still while the serial clock is stopped
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) slot_out <= '0;
        else if (run_in) slot_out <= slot_out + 1'b1;
    end
    // odd frames only, so the two event sources cannot be confused
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) frame_odd <= 1'b0;
        else if (run_in && slot_out == '1) frame_odd <= ~frame_odd;
    end
    assign tx_sync_out = run_in && frame_odd && slot_out == 2;
    assign rx_sync_out = run_in && frame_odd && slot_out == 3;
endmodule

// ### dv/tb.sv
// Purpose: self-checking bench of the group config block
// Assumes: zero-wait ahb-lite slave, small slot counter
// Notes: the block is reset between the polling runs
`timescale 1ns/100ps
module tb;
    localparam int SW = 3;
    logic sys_clk_in = 1'b0, rst_n_in = 1'b0, hsel_in = 1'b0, hwrite_in = 1'b0;
    logic [11:0] haddr_in = 12'h000;
    logic [1:0] htrans_in = 2'h0;
    logic [31:0] hwdata_in = 32'h0, hrdata_out, run_exp, r;
    logic tx_frame_sync_in, rx_frame_sync_in, srun = 1'b0, su_error_in = 1'b0;
    logic channel_activate_in = 1'b0, tx_buffer_end_in = 1'b0, rx_buffer_end_in = 1'b0;
    logic mem_violation_in = 1'b0, hreadyout_out, hresp_out, frame_sync_out;
    logic [4:0] activate_channel_in = 5'h00, serviced_channel_in = 5'h09;
    logic [SW-1:0] time_slot_in;
    logic poll_strobe_out, tx_status_wb_out, rx_status_wb_out, su_error_interrupt_out, irq_out;
    logic [31:0] channel_running_out;
    cgc_pkg::cgc_deact_t deact_out;
    int n_fail = 0, tests_run = 0, causes;
    cgc_group_config #(.SLOT_W(SW)) cgc_group_config_inst (.sys_clk_in, .rst_n_in,
        .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in(3'h2), .hwdata_in,
        .hready_in(hreadyout_out), .hrdata_out, .hreadyout_out, .hresp_out, .time_slot_in,
        .tx_frame_sync_in, .rx_frame_sync_in, .su_error_in, .channel_activate_in,
        .activate_channel_in, .tx_buffer_end_in, .rx_buffer_end_in, .mem_violation_in,
        .serviced_channel_in, .frame_sync_out, .poll_strobe_out, .channel_running_out,
        .tx_status_wb_out, .rx_status_wb_out, .deact_out, .su_error_interrupt_out, .irq_out);
    cgc_serial_model #(.SLOT_W(SW)) cgc_serial_model_inst (.clk_in(sys_clk_in), .rst_n_in,
        .run_in(srun), .slot_out(time_slot_in), .tx_sync_out(tx_frame_sync_in),
        .rx_sync_out(rx_frame_sync_in));
    ////////////////////////////////////////////////////////////////
    initial begin
        forever #50 sys_clk_in = ~sys_clk_in;
    end
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one single transfer; holds each phase until hready is sampled high
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge sys_clk_in);
        hsel_in <= 1'b1;
        htrans_in <= 2'h2;
        haddr_in <= a;
        hwrite_in <= w;
        do @(posedge sys_clk_in); while (hreadyout_out !== 1'b1);
        hsel_in <= 1'b0;
        htrans_in <= 2'h0;
        hwdata_in <= d;
        do @(posedge sys_clk_in); while (hreadyout_out !== 1'b1);
        q = hrdata_out;
    endtask
    task automatic load(input logic [31:0] cfg);
        logic [31:0] q;
        bus(1'b1, 12'h000, cfg, q);
        bus(1'b1, 12'h008, 32'h12, q);
        repeat (6) @(posedge sys_clk_in);
        bus(1'b0, 12'h004, 32'h0, q);
        check("active word", cfg, q);
    endtask
    task automatic do_reset();
        rst_n_in <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
    endtask
    task automatic pulse_events();
        @(posedge sys_clk_in);
        {tx_buffer_end_in, rx_buffer_end_in, mem_violation_in} <= 3'b111;
        @(posedge sys_clk_in);
        {tx_buffer_end_in, rx_buffer_end_in, mem_violation_in} <= 3'b000;
        @(negedge sys_clk_in);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // watchdog, far beyond the roughly 1400 cycles the run needs
    initial begin
        #2000000;
        n_fail++;
        stop_test();
    end
    initial begin
        do_reset();
        bus(1'b1, 12'h000, 32'h00008800, r);
        bus(1'b0, 12'h004, 32'h0, r);
        check("active before load", 32'h00000400, r);
        // throttle codes 1 to 3; the middle one uses the external sync
        for (int t = 1; t < 4; t++) begin
            do_reset();
            load((32'(t == 2) << 15) | (32'(t) << 10));
            @(posedge sys_clk_in);
            channel_activate_in <= 1'b1;
            activate_channel_in <= 5'(t + 4);
            @(posedge sys_clk_in);
            channel_activate_in <= 1'b0;
            repeat (4) @(negedge sys_clk_in);
            check("running before sync", 32'h0, channel_running_out);
            @(posedge sys_clk_in);
            srun <= 1'b1;
            causes = 0;
            @(negedge sys_clk_in);
            while (poll_strobe_out !== 1'b1) begin
                if (t == 2 ? tx_frame_sync_in : time_slot_in == '1) causes++;
                @(negedge sys_clk_in);
            end
            check("events per poll", 32'h10 << (t - 1), causes);
            check("running", 32'h1 << (t + 4), channel_running_out);
            @(posedge sys_clk_in);
            srun <= 1'b0;
        end
        run_exp = 32'h80;
        for (int i = 3; i >= 0; i--) begin
            load(32'h400 | (32'(i) << 8) | (32'(i % 2) << 7));
            pulse_events();
            check("tx wb", 32'(i < 2), 32'(tx_status_wb_out));
            check("rx wb", 32'(i % 2 == 0), 32'(rx_status_wb_out));
            check("deact valid", 32'h1, 32'(deact_out.valid));
            check("deact all", 32'(i % 2 == 0), 32'(deact_out.all));
            if (i % 2 == 1) check("deact ch", 32'h9, 32'(deact_out.channel));
            run_exp = (i % 2 == 1) ? run_exp & ~32'h200 : 32'h0;
            repeat (3) @(negedge sys_clk_in);
            check("running after", run_exp, channel_running_out);
        end
        bus(1'b0, 12'h010, 32'h0, r);
        check("irq status", 32'h1e, {26'h0, r[5:0]});
        check("irq masked", 32'h0, 32'(irq_out));
        bus(1'b1, 12'h018, 32'h4, r);
        @(negedge sys_clk_in);
        check("irq on", 32'h1, 32'(irq_out));
        bus(1'b1, 12'h014, 32'h3f, r);
        @(negedge sys_clk_in);
        check("irq cleared", 32'h0, 32'(irq_out));
        bus(1'b1, 12'h0f0, 32'h5a5a, r);
        bus(1'b0, 12'h0f0, 32'h0, r);
        check("unmapped", 32'h0, r);
        // threshold 2: the third error is the first over it
        load(32'h00020400);
        for (int k = 1; k < 4; k++) begin
            @(posedge sys_clk_in);
            su_error_in <= 1'b1;
            @(posedge sys_clk_in);
            su_error_in <= 1'b0;
            repeat (3) @(negedge sys_clk_in);
            check("su irq", 32'(k > 2), 32'(su_error_interrupt_out));
        end
        bus(1'b0, 12'h01c, 32'h0, r);
        check("su count", 32'h3, r);
        stop_test();
    end
endmodule
